// file: standby_reset_defines.vh
// Constants for the stop mode and reset sequencer
`ifndef STANDBY_RESET_DEFINES_VH
`define STANDBY_RESET_DEFINES_VH

// Register byte addresses
`define REG_CTRL 4'h0
`define REG_STAT 4'h4
`define REG_CAUSE 4'h8
`define REG_INTR 4'hc

// Control register fields
`define CTRL_XTAL_BIT 0
`define CTRL_LSOSC_STOP_BIT 1
`define CTRL_LSOSC_STOPPABLE_BIT 2
`define CTRL_TIMER2_LSCLK_BIT 3
`define CTRL_WDT_LSCLK_BIT 4
`define CTRL_RESET_AS_PORT_BIT 5
`define CTRL_STAB_SEL_LSB 8
`define CTRL_STAB_SEL_MSB 10
`define CTRL_RESET 32'h0000_0004

// Interrupt request register fields
`define INTR_MASK_LSB 0
`define INTR_MASK_MSB 7
`define INTR_REQ_LSB 8
`define INTR_REQ_MSB 15
`define INTR_GIE_BIT 16
`define INTR_MASK_RESET 8'hff

// Sequencer states
`define ST_RESET 3'h0
`define ST_OPTION 3'h1
`define ST_STAB 3'h2
`define ST_RUN 3'h3
`define ST_STOP 3'h4
`define ST_WAKE 3'h5
`define ST_WAKE_LS 3'h6

// Timing: 8 low-speed clocks and 96 high-speed clocks
`define OPT_LS_CYCLES 8'h08
`define OPT_HS_CYCLES 8'h60
`define HS_PER_SYS 8'h01
`define EXT_RESET_MIN_NS 1000
`define CYCLE_NS 5

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: stop_mode_and_reset_control.v
// Stop mode control, reset source gathering and reset release sequencing
// Operation
// - Stop entered only by stop instruction
// - Pending unmasked interrupt aborts stop, eight-clock wait
// - Stop halts main clock and processor
// - Stop halts timers, converter, serial unit
// - Second timer runs on running low-speed clock
// - Watchdog runs on running low-speed clock
// - Unmasked interrupt wakes; enable picks service/next
// - Reset in stop: reset after stabilization
// - Option read holds eight plus ninety-six clocks
// - Four reset sources: pin, watchdog, supply
// - All resets alike; fetch vector at zero
// - Pins float in reset, indicator drives low
// - Pin high releases; option then stabilization
// - Watchdog reset releases itself
// - Supply resets release when voltage recovers
// - Reset stops both oscillators
// - Input-port reset pin still resets early
// - Option setting selects stabilization time
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "standby_reset_defines.vh"

module stop_mode_and_reset_control #(
  parameter LS_DIV = 1024,
  parameter STAB_UNIT = 16
) (
  input wire clk_sys,
  input wire resetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire stop_instr,
  input wire reset_pin_n,
  input wire watchdog_overflow,
  input wire power_on_clear,
  input wire low_voltage_detector,
  input wire [7:0] irq_pulse,
  output reg cpu_run,
  output reg cpu_reset,
  output reg [15:0] fetch_vector,
  output reg irq_service,
  output reg main_osc_en,
  output reg low_speed_osc_en,
  output reg periph_stop,
  output reg second_8bit_timer_en,
  output reg watchdog_clk_en,
  output reg pins_hiz,
  output reg reset_indicator_pin_o,
  output reg reset_indicator_pin_oe
);

  reg [31:0] ctrl_q;
  reg [7:0] interrupt_mask_flag_q;
  reg [7:0] irq_req_q;
  reg global_interrupt_enable_q;
  reg [3:0] cause_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [15:0] cnt_q;
  reg [15:0] cnt_d;
  reg [15:0] ls_div_q;
  reg [3:0] req_meta_q;
  reg [3:0] req_sync_q;
  reg opt_done_q;
  reg aw_hold_q;
  reg w_hold_q;
  reg [3:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  wire ls_tick = (ls_div_q == LS_DIV - 1);
  wire xtal = ctrl_q[`CTRL_XTAL_BIT];
  wire ls_stopped = ctrl_q[`CTRL_LSOSC_STOPPABLE_BIT] & ctrl_q[`CTRL_LSOSC_STOP_BIT];
  wire [2:0] stabilization_time_select = ctrl_q[`CTRL_STAB_SEL_MSB:`CTRL_STAB_SEL_LSB];
  wire reset_req = |req_sync_q;
  wire pend = |(irq_req_q & ~interrupt_mask_flag_q);
  wire wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire [15:0] stab_cycles = (16'h0001 << stabilization_time_select) * STAB_UNIT[15:0];
  wire [15:0] opt_cycles = `OPT_LS_CYCLES * LS_DIV[15:0] + `OPT_HS_CYCLES * `HS_PER_SYS;

  // Byte-lane merge used for the control register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] neu;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) merge[i*8 +: 8] = neu[i*8 +: 8];
      end
    end
  endfunction

  // States in which the processor is held and pins float
  function held_in_reset;
    input [2:0] st;
    begin
      held_in_reset = (st == `ST_RESET) || (st == `ST_OPTION) || (st == `ST_STAB);
    end
  endfunction

  // A timer on the slow clock survives stop unless that clock is off
  function lsclk_gate;
    input sel_ls;
    input [2:0] st;
    input ls_off;
    begin
      lsclk_gate = sel_ls ? ((st != `ST_RESET) && !ls_off) : (st == `ST_RUN);
    end
  endfunction

  // Reset sources; reset-as-port pin still resets before option read ends
  wire pin_rst = ~reset_pin_n &
    (~ctrl_q[`CTRL_RESET_AS_PORT_BIT] | ~opt_done_q);
  wire [3:0] raw_req = {low_voltage_detector, power_on_clear, watchdog_overflow, pin_rst};

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      req_meta_q <= 4'h0;
      req_sync_q <= 4'h0;
    end else begin
      req_meta_q <= raw_req;
      req_sync_q <= req_meta_q;
    end
  end

  // Low-speed tick divider, held at zero while a reset request holds the oscillator off
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ls_div_q <= 16'h0000;
    end else if (reset_req || ls_tick) begin
      ls_div_q <= 16'h0000;
    end else begin
      ls_div_q <= ls_div_q + 16'h0001;
    end
  end

  // Sequencer
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      `ST_RESET: begin
        cnt_d = 16'h0000;
        if (!reset_req) state_d = `ST_OPTION;
      end
      `ST_OPTION: begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q >= opt_cycles - 16'h0001) begin
          cnt_d = 16'h0000;
          state_d = xtal ? `ST_STAB : `ST_RUN;
        end
      end
      `ST_STAB: begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q >= stab_cycles - 16'h0001) begin
          cnt_d = 16'h0000;
          state_d = `ST_RUN;
        end
      end
      `ST_RUN: begin
        cnt_d = 16'h0000;
        // Pending request aborts entry; a crystal still needs its wait
        if (stop_instr && pend) state_d = xtal ? `ST_WAKE : `ST_WAKE_LS;
        else if (stop_instr) state_d = `ST_STOP;
      end
      `ST_STOP: begin
        // Held while every request is masked
        cnt_d = 16'h0000;
        if (pend) state_d = xtal ? `ST_WAKE : `ST_WAKE_LS;
      end
      `ST_WAKE: begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q >= stab_cycles - 16'h0001) begin
          cnt_d = 16'h0000;
          state_d = `ST_WAKE_LS;
        end
      end
      `ST_WAKE_LS: begin
        if (ls_tick) cnt_d = cnt_q + 16'h0001;
        if (ls_tick && cnt_q >= `OPT_LS_CYCLES - 16'h0001) begin
          cnt_d = 16'h0000;
          state_d = `ST_RUN;
        end
      end
      default: begin
        cnt_d = 16'h0000;
        state_d = `ST_RESET;
      end
    endcase
    // Any source forces the same reset path, also out of stop
    if (reset_req) begin
      state_d = `ST_RESET;
      cnt_d = 16'h0000;
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= `ST_RESET;
      cnt_q <= 16'h0000;
      opt_done_q <= 1'b0;
      cause_q <= 4'h0;
      cpu_run <= 1'b0;
      cpu_reset <= 1'b1;
      fetch_vector <= 16'h0000;
      irq_service <= 1'b0;
      main_osc_en <= 1'b0;
      low_speed_osc_en <= 1'b0;
      periph_stop <= 1'b1;
      second_8bit_timer_en <= 1'b0;
      watchdog_clk_en <= 1'b0;
      pins_hiz <= 1'b1;
      reset_indicator_pin_o <= 1'b0;
      reset_indicator_pin_oe <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (state_d == `ST_RESET) opt_done_q <= 1'b0;
      else if (state_q == `ST_OPTION && state_d != `ST_OPTION) opt_done_q <= 1'b1;
      // Sticky causes of all resets since the last clear; new cause overrides software clear
      if (reset_req) cause_q <= cause_q | req_sync_q;
      else if (wr_go && aw_addr_q == `REG_CAUSE) cause_q <= cause_q & ~w_data_q[3:0];
      cpu_run <= (state_d == `ST_RUN);
      cpu_reset <= held_in_reset(state_d);
      fetch_vector <= 16'h0000;
      irq_service <= (state_q == `ST_WAKE_LS) && (state_d == `ST_RUN) &&
        global_interrupt_enable_q;
      main_osc_en <= (state_d != `ST_RESET) && (state_d != `ST_STOP);
      low_speed_osc_en <= (state_d != `ST_RESET) && !ls_stopped;
      periph_stop <= (state_d != `ST_RUN);
      second_8bit_timer_en <= lsclk_gate(ctrl_q[`CTRL_TIMER2_LSCLK_BIT], state_d,
        ls_stopped);
      watchdog_clk_en <= lsclk_gate(ctrl_q[`CTRL_WDT_LSCLK_BIT], state_d,
        ls_stopped);
      pins_hiz <= held_in_reset(state_d);
      reset_indicator_pin_oe <= held_in_reset(state_d);
      reset_indicator_pin_o <= 1'b0;
    end
  end

  // Interrupt requests, masks and enable
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_req_q <= 8'h00;
      interrupt_mask_flag_q <= `INTR_MASK_RESET;
      global_interrupt_enable_q <= 1'b0;
    end else begin
      if (wr_go && aw_addr_q == `REG_INTR) begin
        if (w_strb_q[0]) interrupt_mask_flag_q <= w_data_q[`INTR_MASK_MSB:`INTR_MASK_LSB];
        if (w_strb_q[2]) global_interrupt_enable_q <= w_data_q[`INTR_GIE_BIT];
      end
      // Request set wins over a same-cycle software clear
      if (wr_go && aw_addr_q == `REG_INTR && w_strb_q[1])
        irq_req_q <= (irq_req_q & ~w_data_q[`INTR_REQ_MSB:`INTR_REQ_LSB]) | irq_pulse;
      else
        irq_req_q <= irq_req_q | irq_pulse;
    end
  end

  // AXI4-Lite slave; write channels accepted in either order
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      ctrl_q <= `CTRL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q == `REG_CTRL || aw_addr_q == `REG_CAUSE ||
          aw_addr_q == `REG_INTR) ? `RESP_OKAY : `RESP_SLVERR;
        if (aw_addr_q == `REG_CTRL) ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (s_axi_araddr)
          `REG_CTRL: s_axi_rdata <= ctrl_q;
          `REG_STAT: s_axi_rdata <= {25'h0, opt_done_q, cpu_run, 2'h0, state_q};
          `REG_CAUSE: s_axi_rdata <= {28'h0, cause_q};
          `REG_INTR: s_axi_rdata <= {15'h0, global_interrupt_enable_q, irq_req_q,
            interrupt_mask_flag_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// file: stop_mode_and_reset_control_assertions.sv
// Port checks for the stop mode and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module stop_mode_and_reset_control_assertions #(
  parameter LS_DIV = 1024
) (
  input wire clk_sys,
  input wire resetn,
  input wire stop_instr,
  input wire reset_pin_n,
  input wire watchdog_overflow,
  input wire power_on_clear,
  input wire low_voltage_detector,
  input wire cpu_run,
  input wire cpu_reset,
  input wire [15:0] fetch_vector,
  input wire irq_service,
  input wire main_osc_en,
  input wire low_speed_osc_en,
  input wire periph_stop,
  input wire second_8bit_timer_en,
  input wire watchdog_clk_en,
  input wire pins_hiz,
  input wire reset_indicator_pin_o,
  input wire reset_indicator_pin_oe
);
  wire src = !reset_pin_n || watchdog_overflow || power_on_clear || low_voltage_detector;
  reg [15:0] quiet_q;
  // Counts quiet cycles; saturates so long runs never wrap
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn || src)
      quiet_q <= 16'h0000;
    else if (quiet_q != 16'hffff)
      quiet_q <= quiet_q + 16'h0001;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_hiz; pins_hiz |-> reset_indicator_pin_oe && !reset_indicator_pin_o; endproperty
  a_hiz: assert property (p_hiz) else $error("indicator pin wrong");
  property p_vec; fetch_vector == 16'h0000; endproperty
  a_vec: assert property (p_vec) else $error("fetch vector wrong");
  property p_src; src [*4] |-> cpu_reset && !cpu_run && !main_osc_en && !low_speed_osc_en; endproperty
  a_src: assert property (p_src) else $error("source did not reset");
  property p_opt; $fell(cpu_reset) |-> quiet_q >= 8 * LS_DIV + 96; endproperty
  a_opt: assert property (p_opt) else $error("option hold too short");
  property p_stop; $fell(cpu_run) && !cpu_reset |-> $past(stop_instr) || $past(stop_instr, 2); endproperty
  a_stop: assert property (p_stop) else $error("stop without instruction");
  property p_sleep; !main_osc_en && !cpu_reset |-> !cpu_run && periph_stop; endproperty
  a_sleep: assert property (p_sleep) else $error("stop state outputs wrong");
  property p_run; cpu_run |-> main_osc_en && !periph_stop && !pins_hiz; endproperty
  a_run: assert property (p_run) else $error("run state outputs wrong");
  property p_ls; !low_speed_osc_en && !main_osc_en && !cpu_reset |-> !second_8bit_timer_en && !watchdog_clk_en; endproperty
  a_ls: assert property (p_ls) else $error("timer runs without clock");
  property p_irq; irq_service |-> !cpu_reset ##1 !irq_service; endproperty
  a_irq: assert property (p_irq) else $error("service pulse wrong");
endmodule
`default_nettype wire

// file: far_side_model.sv
// Processor core, reset pin and supply detector model
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input wire clk_sys,
  output logic stop_instr,
  output logic reset_pin_n,
  output logic watchdog_overflow,
  output logic power_on_clear,
  output logic low_voltage_detector,
  output logic [7:0] irq_pulse
);
  initial begin
    {stop_instr, watchdog_overflow, power_on_clear, low_voltage_detector} = 4'h0;
    reset_pin_n = 1'b1;
    irq_pulse = 8'h00;
  end
  task automatic exec_stop();
    @(posedge clk_sys) stop_instr <= 1'b1;
    @(posedge clk_sys) stop_instr <= 1'b0;
  endtask
  task automatic pulse_irq(input int i);
    @(posedge clk_sys) irq_pulse <= 8'h01 << i;
    @(posedge clk_sys) irq_pulse <= 8'h00;
  endtask
  // k: 0 pin, 1 watchdog, 2 power-on, 3 low voltage
  task automatic raise_src(input int k, input int n);
    @(posedge clk_sys);
    reset_pin_n <= (k != 0);
    watchdog_overflow <= (k == 1);
    power_on_clear <= (k == 2);
    low_voltage_detector <= (k == 3);
    repeat ((k == 0 && n < 200) ? 200 : n) @(posedge clk_sys);
    reset_pin_n <= 1'b1;
    {watchdog_overflow, power_on_clear, low_voltage_detector} <= 3'h0;
  endtask
endmodule
`default_nettype wire

// file: stop_mode_and_reset_control_test.sv
// Self-checking bench for the stop mode and reset sequencer
`timescale 1ns/1ps
`default_nettype none
`include "standby_reset_defines.vh"
module stop_mode_and_reset_control_test;
  localparam int OPT = 8 * 4 + 96;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] fetch_vector;
  wire [7:0] irq_pulse;
  wire stop_instr, reset_pin_n, watchdog_overflow, power_on_clear, low_voltage_detector;
  wire cpu_run, cpu_reset, irq_service, main_osc_en, low_speed_osc_en, periph_stop;
  wire second_8bit_timer_en, watchdog_clk_en, pins_hiz;
  wire reset_indicator_pin_o, reset_indicator_pin_oe;
  int miscompares = 0;
  int total_checks = 0;
  int svc_cnt = 0;
  stop_mode_and_reset_control #(.LS_DIV(4), .STAB_UNIT(2)) dut_u (.*);
  far_side_model far_u (.*);
  initial forever #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (irq_service === 1'b1) svc_cnt <= svc_cnt + 1;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_sys);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", `RESP_OKAY, s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    chk("rresp", `RESP_OKAY, s_axi_rresp);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_run(output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (cpu_run !== 1'b1 && n < 2000);
    chk("run_reached", 1, cpu_run);
  endtask
  task automatic sc_boot();
    logic [31:0] d;
    int n;
    chk("hiz", 1, pins_hiz);
    chk("ind_oe", 1, reset_indicator_pin_oe);
    chk("ls_osc_off", 0, low_speed_osc_en);
    wait_run(n);
    chk("boot_hold", 1, n >= OPT);
    chk("vector", 16'h0000, fetch_vector);
    rd(`REG_CTRL, d);
    chk("ctrl", `CTRL_RESET, d);
    rd(`REG_STAT, d);
    chk("stat", 32'h0000_0063, d);
    rd(`REG_INTR, d);
    chk("intr", 32'h0000_00ff, d);
  endtask
  task automatic sc_masked();
    int n;
    int s0;
    s0 = svc_cnt;
    wr(`REG_INTR, 32'h0000_ffff, 4'h3);
    far_u.exec_stop();
    far_u.pulse_irq(2);
    repeat (100) @(posedge clk_sys);
    chk("masked_hold", 0, cpu_run);
    chk("main_osc", 0, main_osc_en);
    chk("periph", 1, periph_stop);
    // Unmasking a pending request must wake without service
    wr(`REG_INTR, 32'h0000_00fb, 4'h1);
    wait_run(n);
    chk("wake", 1, cpu_run);
    chk("no_service", 0, svc_cnt - s0);
  endtask
  task automatic sc_gie();
    int n;
    int s0;
    wr(`REG_INTR, 32'h0001_fffb, 4'h7);
    s0 = svc_cnt;
    far_u.exec_stop();
    repeat (20) @(posedge clk_sys);
    chk("stop_entered", 0, cpu_run);
    far_u.pulse_irq(2);
    wait_run(n);
    repeat (4) @(posedge clk_sys);
    chk("service", 1, svc_cnt - s0);
  endtask
  task automatic sc_pending();
    int n;
    wr(`REG_INTR, 32'h0000_fffb, 4'h7);
    far_u.pulse_irq(2);
    far_u.exec_stop();
    wait_run(n);
    // Tick phase of the slow clock adds up to one tick of slack
    chk("pending_wait", 1, n >= 28 && n <= 44);
  endtask
  task automatic sc_sources();
    logic [31:0] d;
    int n;
    // Drop the leftover request so the stop below is a real stop
    wr(`REG_INTR, 32'h0000_ffff, 4'h3);
    for (int k = 0; k < 4; k++) begin
      wr(`REG_CAUSE, 32'h0000_000f, 4'h1);
      if (k == 1) far_u.exec_stop();
      far_u.raise_src(k, 20);
      chk("held", 1, cpu_reset);
      wait_run(n);
      chk("restart", 1, n >= OPT);
      rd(`REG_CAUSE, d);
      chk("cause", 32'h1 << k, d);
    end
  endtask
  task automatic sc_clocks();
    int n;
    wr(`REG_INTR, 32'h0000_fffb, 4'h7);
    wr(`REG_CTRL, 32'h0000_011f, 4'h3);
    far_u.exec_stop();
    repeat (4) @(posedge clk_sys);
    chk("ls_off", 0, low_speed_osc_en);
    chk("timer_off", 0, second_8bit_timer_en);
    chk("wdt_off", 0, watchdog_clk_en);
    far_u.pulse_irq(2);
    wait_run(n);
    chk("xtal_wake", 1, n >= 4 + 29);
    wr(`REG_CTRL, 32'h0000_011d, 4'h3);
    wr(`REG_INTR, 32'h0000_fffb, 4'h7);
    far_u.exec_stop();
    repeat (4) @(posedge clk_sys);
    chk("timer_ls", 1, second_8bit_timer_en);
    chk("wdt_ls", 1, watchdog_clk_en);
    far_u.raise_src(1, 20);
    wait_run(n);
    chk("xtal_boot", 1, n >= OPT + 4);
  endtask
  task automatic close_out();
    if (miscompares == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    sc_boot();
    sc_masked();
    sc_gie();
    sc_pending();
    sc_sources();
    sc_clocks();
    close_out();
  end
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule
bind stop_mode_and_reset_control stop_mode_and_reset_control_assertions #(.LS_DIV(LS_DIV)) chk_u (.*);
`default_nettype wire
